// [include/fcd_pkg.sv]
// package for the flash command host controller
// assumes a 25 MHz system clock and a parallel flash with command interface
`default_nettype none
package fcd_pkg;
  // clock and bus timing
  localparam int CLK_MHZ = 25;
  localparam int ABORT_US = 10;
  localparam int ABORT_CYC = ABORT_US * CLK_MHZ;
  localparam int STROBE_CYC = 3;
  // wishbone register offsets (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_DATA = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;
  // control field positions
  localparam int CTRL_GO = 0;
  localparam int CTRL_BYTE = 1;
  localparam int CTRL_CMD_LSB = 4;
  localparam int CTRL_CMD_W = 4;
  // status field positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_BYPASS = 1;
  localparam int STAT_SUSP = 2;
  localparam int STAT_IDENT = 3;
  // command data values
  localparam logic [7:0] D_UNLOCK1 = 8'hAA;
  localparam logic [7:0] D_UNLOCK2 = 8'h55;
  localparam logic [7:0] D_RESET = 8'hF0;
  localparam logic [7:0] D_IDENT = 8'h90;
  localparam logic [7:0] D_PROG = 8'hA0;
  localparam logic [7:0] D_BYPASS = 8'h20;
  localparam logic [7:0] D_ERASE = 8'h80;
  localparam logic [7:0] D_CHIP = 8'h10;
  localparam logic [7:0] D_BLOCK = 8'h30;
  localparam logic [7:0] D_SUSP = 8'hB0;
  localparam logic [7:0] D_RESUME = 8'h30;
  localparam logic [7:0] D_EXIT2 = 8'h00;
  // unlock addresses
  localparam logic [11:0] W_ADDR1 = 12'h555;
  localparam logic [11:0] W_ADDR2 = 12'h2AA;
  localparam logic [11:0] B_ADDR1 = 12'hAAA;
  localparam logic [11:0] B_ADDR2 = 12'h555;
  // identification reads
  localparam logic [1:0] ID_MAKER = 2'h0;
  localparam logic [1:0] ID_PART = 2'h1;
  localparam logic [1:0] ID_PROT = 2'h2;
  // host-level operations
  typedef enum logic [3:0] {
    FCD_OP_RESET1, FCD_OP_RESET3, FCD_OP_IDENT, FCD_OP_PROG,
    FCD_OP_BYPASS, FCD_OP_BPROG, FCD_OP_BEXIT, FCD_OP_CHIP,
    FCD_OP_BLOCK, FCD_OP_SUSP, FCD_OP_RESUME, FCD_OP_READ,
    FCD_OP_BLKADD
  } fcd_op_e;
endpackage : fcd_pkg
`default_nettype wire

// [logic/fcd_host.sv]
// host controller that issues flash command sequences over the pin bus
// assumes a wishbone classic master and a flash wired to the pin ports
`default_nettype none
module fcd_host (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // flash pins
  output logic [19:0] fl_addr_o,
  output logic fl_ce_n_o,
  output logic fl_we_n_o,
  output logic fl_oe_n_o,
  input wire logic [14:0] fl_dq_i,
  output logic [14:0] fl_dq_o,
  output logic fl_dq_oe_o,
  input wire logic top_data_or_low_address_pin_i,
  output logic top_data_or_low_address_pin_o,
  output logic top_data_or_low_address_pin_oe_o,
  output logic fl_byte_n_o
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    FCD_IDLE, FCD_SETUP, FCD_STROBE, FCD_HOLD, FCD_WAIT
  } fcd_st_e;
  fcd_st_e st_ff, nxt_st;
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [20:0] adr_ff, nxt_adr;
  logic [15:0] dat_ff, nxt_dat;
  logic [15:0] rd_ff, nxt_rd;
  logic [2:0] step_ff, nxt_step;
  logic [2:0] len_ff, nxt_len;
  logic [8:0] cnt_ff, nxt_cnt;
  logic bypass_ff, nxt_bypass;
  logic susp_ff, nxt_susp;
  logic ident_ff, nxt_ident;
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic busy;
  logic bus_req;
  logic cur_wr;
  logic [20:0] cur_a;
  logic [15:0] cur_d;
  fcd_pkg::fcd_op_e op;
  // sequence length for each operation
  function automatic logic [2:0] op_len(input fcd_pkg::fcd_op_e o);
    unique case (o)
      fcd_pkg::FCD_OP_RESET1, fcd_pkg::FCD_OP_SUSP, fcd_pkg::FCD_OP_RESUME,
      fcd_pkg::FCD_OP_READ, fcd_pkg::FCD_OP_BLKADD: op_len = 3'h1;
      fcd_pkg::FCD_OP_BPROG, fcd_pkg::FCD_OP_BEXIT: op_len = 3'h2;
      fcd_pkg::FCD_OP_RESET3, fcd_pkg::FCD_OP_IDENT,
      fcd_pkg::FCD_OP_BYPASS: op_len = 3'h3;
      fcd_pkg::FCD_OP_PROG: op_len = 3'h4;
      default: op_len = 3'h6;
    endcase
  endfunction : op_len
  // unlock addresses depend on width; both are in word/byte bus units
  function automatic logic [11:0] ul_addr(input logic bm, input logic sec);
    if (bm) begin
      ul_addr = sec ? fcd_pkg::B_ADDR2 : fcd_pkg::B_ADDR1;
    end else begin
      ul_addr = sec ? fcd_pkg::W_ADDR2 : fcd_pkg::W_ADDR1;
    end
  endfunction : ul_addr
  assign op = fcd_pkg::fcd_op_e'(ctrl_ff[fcd_pkg::CTRL_CMD_LSB +: 4]);
  assign busy = (st_ff != FCD_IDLE);
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  // ------------------------------------------------------------------
  // current write or read of the sequence (address, data)
  // ------------------------------------------------------------------
  // the address register holds the target in bus units (word or byte); bit 0 is the
  // low address pin in byte mode only
  always_comb begin
    logic bm;
    logic [11:0] u1;
    logic [11:0] u2;
    bm = ctrl_ff[fcd_pkg::CTRL_BYTE];
    u1 = ul_addr(bm, 1'b0);
    u2 = ul_addr(bm, 1'b1);
    cur_wr = 1'b1;
    cur_a = {9'h000, u1};
    cur_d = {8'h00, fcd_pkg::D_RESET};
    // unlock pair shared by the long sequences
    if (step_ff == 3'h0 || step_ff == 3'h3) begin
      cur_a = {9'h000, u1};
      cur_d = {8'h00, fcd_pkg::D_UNLOCK1};
    end else if (step_ff == 3'h1 || step_ff == 3'h4) begin
      cur_a = {9'h000, u2};
      cur_d = {8'h00, fcd_pkg::D_UNLOCK2};
    end
    unique case (op)
      fcd_pkg::FCD_OP_RESET1: cur_d = {8'h00, fcd_pkg::D_RESET};
      fcd_pkg::FCD_OP_RESET3: begin
        if (step_ff == 3'h2) cur_d = {8'h00, fcd_pkg::D_RESET};
      end
      fcd_pkg::FCD_OP_IDENT: begin
        if (step_ff == 3'h2) cur_d = {8'h00, fcd_pkg::D_IDENT};
      end
      fcd_pkg::FCD_OP_BYPASS: begin
        if (step_ff == 3'h2) cur_d = {8'h00, fcd_pkg::D_BYPASS};
      end
      fcd_pkg::FCD_OP_PROG: begin
        if (step_ff == 3'h2) cur_d = {8'h00, fcd_pkg::D_PROG};
        if (step_ff == 3'h3) begin
          cur_a = adr_ff;
          cur_d = dat_ff;
        end
      end
      fcd_pkg::FCD_OP_BPROG: begin
        cur_d = {8'h00, fcd_pkg::D_PROG};
        if (step_ff == 3'h1) begin
          cur_a = adr_ff;
          cur_d = dat_ff;
        end
      end
      fcd_pkg::FCD_OP_BEXIT: begin
        cur_d = (step_ff == 3'h0) ? {8'h00, fcd_pkg::D_IDENT} :
                {8'h00, fcd_pkg::D_EXIT2};
      end
      fcd_pkg::FCD_OP_CHIP, fcd_pkg::FCD_OP_BLOCK: begin
        if (step_ff == 3'h2) cur_d = {8'h00, fcd_pkg::D_ERASE};
        if (step_ff == 3'h5) begin
          if (op == fcd_pkg::FCD_OP_CHIP) begin
            cur_d = {8'h00, fcd_pkg::D_CHIP};
          end else begin
            cur_a = adr_ff;
            cur_d = {8'h00, fcd_pkg::D_BLOCK};
          end
        end
      end
      fcd_pkg::FCD_OP_BLKADD: begin
        cur_a = adr_ff;
        cur_d = {8'h00, fcd_pkg::D_BLOCK};
      end
      fcd_pkg::FCD_OP_SUSP: cur_d = {8'h00, fcd_pkg::D_SUSP};
      fcd_pkg::FCD_OP_RESUME: cur_d = {8'h00, fcd_pkg::D_RESUME};
      fcd_pkg::FCD_OP_READ: begin
        cur_wr = 1'b0;
        cur_a = adr_ff;
      end
      default: cur_wr = 1'b1;
    endcase
  end
  // ------------------------------------------------------------------
  // sequencer and register file next state
  // ------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_ctrl = ctrl_ff;
    nxt_adr = adr_ff;
    nxt_dat = dat_ff;
    nxt_rd = rd_ff;
    nxt_step = step_ff;
    nxt_len = len_ff;
    nxt_cnt = cnt_ff;
    nxt_bypass = bypass_ff;
    nxt_susp = susp_ff;
    nxt_ident = ident_ff;
    nxt_ack = 1'b0;
    nxt_rdat = rdat_ff;
    // wishbone: single-cycle answer; writes ignored while a sequence runs
    if (bus_req) begin
      nxt_ack = 1'b1;
      if (wb_we_i && !busy && wb_sel_i[0]) begin
        unique case (wb_adr_i)
          fcd_pkg::REG_CTRL: nxt_ctrl = wb_dat_i;
          fcd_pkg::REG_ADDR: nxt_adr = wb_dat_i[20:0];
          fcd_pkg::REG_DATA: nxt_dat = wb_dat_i[15:0];
          default: nxt_ack = 1'b1;
        endcase
      end
      unique case (wb_adr_i)
        fcd_pkg::REG_CTRL: nxt_rdat = {ctrl_ff[31:1], 1'b0};
        fcd_pkg::REG_ADDR: nxt_rdat = {11'h000, adr_ff};
        fcd_pkg::REG_DATA: nxt_rdat = {rd_ff, dat_ff};
        fcd_pkg::REG_STAT: nxt_rdat = {28'h0000000, ident_ff, susp_ff,
                                       bypass_ff, busy};
        default: nxt_rdat = 32'h00000000;
      endcase
    end
    unique case (st_ff)
      FCD_IDLE: begin
        if (ctrl_ff[fcd_pkg::CTRL_GO]) begin
          nxt_ctrl[fcd_pkg::CTRL_GO] = 1'b0;
          nxt_step = 3'h0;
          nxt_len = op_len(op);
          nxt_cnt = 9'(fcd_pkg::STROBE_CYC);
          nxt_st = FCD_SETUP;
        end
      end
      // address settles with chip enable low and write enable high; device latches it on the
      // later falling edge of write enable, which comes only after setup
      FCD_SETUP: begin
        nxt_cnt = cnt_ff - 9'h001;
        if (cnt_ff == 9'h001) begin
          nxt_cnt = 9'(fcd_pkg::STROBE_CYC);
          nxt_st = FCD_STROBE;
        end
      end
      FCD_STROBE: begin
        nxt_cnt = cnt_ff - 9'h001;
        if (cnt_ff == 9'h001) begin
          if (!cur_wr) nxt_rd = {top_data_or_low_address_pin_i, fl_dq_i};
          nxt_cnt = 9'(fcd_pkg::STROBE_CYC);
          nxt_st = FCD_HOLD; // data stays driven past the rising edge
        end
      end
      FCD_HOLD: begin
        nxt_cnt = cnt_ff - 9'h001;
        if (cnt_ff == 9'h001) begin
          nxt_step = step_ff + 3'h1;
          nxt_cnt = (step_ff + 3'h1 == len_ff) ? 9'h000 :
                    9'(fcd_pkg::STROBE_CYC);
          nxt_st = (step_ff + 3'h1 == len_ff) ? FCD_WAIT : FCD_SETUP;
        end
      end
      FCD_WAIT: begin
        // reset in erase/error needs an abort gap before the next read
        if (op == fcd_pkg::FCD_OP_RESET1 || op == fcd_pkg::FCD_OP_RESET3)
        begin
          if (cnt_ff < 9'(fcd_pkg::ABORT_CYC)) begin
            nxt_cnt = cnt_ff + 9'h001;
          end else begin
            nxt_ident = 1'b0;
            nxt_st = FCD_IDLE;
          end
        end else begin
          nxt_st = FCD_IDLE;
          unique case (op)
            fcd_pkg::FCD_OP_IDENT: nxt_ident = 1'b1;
            fcd_pkg::FCD_OP_BYPASS: nxt_bypass = 1'b1;
            fcd_pkg::FCD_OP_BEXIT: nxt_bypass = 1'b0;
            fcd_pkg::FCD_OP_SUSP: nxt_susp = 1'b1;
            fcd_pkg::FCD_OP_RESUME: nxt_susp = 1'b0;
            fcd_pkg::FCD_OP_READ: nxt_ident = ident_ff;
            default: nxt_ident = 1'b0; // any other command leaves ident
          endcase
        end
      end
      default: nxt_st = FCD_IDLE;
    endcase
  end
  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= FCD_IDLE;
      ctrl_ff <= 32'h00000000;
      adr_ff <= 21'h000000;
      dat_ff <= 16'h0000;
      rd_ff <= 16'h0000;
      step_ff <= 3'h0;
      len_ff <= 3'h1;
      cnt_ff <= 9'h000;
      bypass_ff <= 1'b0;
      susp_ff <= 1'b0;
      ident_ff <= 1'b0;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h00000000;
    end else begin
      st_ff <= nxt_st;
      ctrl_ff <= nxt_ctrl;
      adr_ff <= nxt_adr;
      dat_ff <= nxt_dat;
      rd_ff <= nxt_rd;
      step_ff <= nxt_step;
      len_ff <= nxt_len;
      cnt_ff <= nxt_cnt;
      bypass_ff <= nxt_bypass;
      susp_ff <= nxt_susp;
      ident_ff <= nxt_ident;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end
  // ------------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------------
  // byte mode: top pin carries the low address bit; word mode: data 15
  logic bm_pin;
  logic in_seq;
  assign bm_pin = ctrl_ff[fcd_pkg::CTRL_BYTE];
  assign in_seq = (st_ff == FCD_SETUP) || (st_ff == FCD_STROBE) ||
                  (st_ff == FCD_HOLD);
  assign fl_byte_n_o = ~bm_pin;
  assign fl_addr_o = bm_pin ? cur_a[20:1] : cur_a[19:0];
  assign fl_ce_n_o = ~in_seq;
  assign fl_we_n_o = ~(cur_wr && st_ff == FCD_STROBE);
  assign fl_oe_n_o = ~(!cur_wr && st_ff == FCD_STROBE);
  assign fl_dq_o = cur_d[14:0];
  assign fl_dq_oe_o = in_seq && cur_wr;
  assign top_data_or_low_address_pin_o = bm_pin ? cur_a[0] : cur_d[15];
  assign top_data_or_low_address_pin_oe_o = bm_pin ? in_seq :
                                           (in_seq && cur_wr);
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
endmodule : fcd_host
`default_nettype wire

// [tb/fcd_host_assertions.sv]
// port checker for the flash host controller
// assumes it is bound to fcd_host and sees only its ports
`default_nettype none
module fcd_host_checker (
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // flash pins
  input wire logic [19:0] fl_addr_o,
  input wire logic fl_ce_n_o,
  input wire logic fl_we_n_o,
  input wire logic fl_oe_n_o,
  input wire logic [14:0] fl_dq_o,
  input wire logic fl_dq_oe_o,
  input wire logic fl_byte_n_o,
  input wire logic top_data_or_low_address_pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // bus handshake and pin timing
  // ----------------------------------------
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  // the flash latches data on the rise, so the strobe length matters
  property p_wr_strobe;
    $fell(fl_we_n_o) |-> !fl_we_n_o [*3] ##1 fl_we_n_o;
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("bad strobe");
  property p_wr_setup;
    $fell(fl_we_n_o) |-> $past(fl_ce_n_o, 3) == 1'b0;
  endproperty
  a_wr_setup: assert property (p_wr_setup) else $error("no setup");
  property p_wr_pins;
    !fl_we_n_o |-> fl_oe_n_o && !fl_ce_n_o && fl_dq_oe_o;
  endproperty
  a_wr_pins: assert property (p_wr_pins) else $error("bad write");
  property p_wr_hold;
    !fl_we_n_o |=> $stable(fl_addr_o) && $stable(fl_dq_o);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("no hold");
  property p_rd_free;
    !fl_oe_n_o |-> !fl_dq_oe_o && fl_we_n_o && !fl_ce_n_o;
  endproperty
  a_rd_free: assert property (p_rd_free) else $error("bus clash");
  property p_top_addr;
    !fl_byte_n_o && !fl_ce_n_o |-> top_data_or_low_address_pin_oe_o;
  endproperty
  a_top_addr: assert property (p_top_addr) else $error("pin idle");
  property p_rd_len;
    $fell(fl_oe_n_o) |-> !fl_oe_n_o [*3] ##1 fl_oe_n_o;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("bad read strobe");
  // main scenarios
  c_write: cover property ($fell(fl_we_n_o));
  c_read: cover property ($fell(fl_oe_n_o));
  c_byte: cover property (!fl_byte_n_o && !fl_we_n_o);
endmodule : fcd_host_checker
bind fcd_host fcd_host_checker u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o),
  .fl_addr_o(fl_addr_o),
  .fl_ce_n_o(fl_ce_n_o),
  .fl_we_n_o(fl_we_n_o),
  .fl_oe_n_o(fl_oe_n_o),
  .fl_dq_o(fl_dq_o),
  .fl_dq_oe_o(fl_dq_oe_o),
  .fl_byte_n_o(fl_byte_n_o),
  .top_data_or_low_address_pin_oe_o(top_data_or_low_address_pin_oe_o)
);
`default_nettype wire

// [tb/fcd_flash_model.sv]
// behavioural flash command interface with a 16-word array
// assumes the bench resolves the shared data pins; no busy time
`default_nettype none
module fcd_flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h00A5, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h005A, // arbitrary value
  parameter logic [7:0] PROT_BLK = 8'h01
) (
  // pins
  input wire logic [19:0] addr_i,
  input wire logic ce_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic byte_n_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic dq_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [16];
  logic [19:0] a_lat;
  logic [2:0] step = 3'h0;
  logic ident = 1'b0;
  logic bypass = 1'b0;
  wire logic [11:0] ca;
  wire logic u1;
  wire logic u2;
  initial foreach (mem[i]) mem[i] = 16'hFFFF;
  // command address: top pin joins A0-A10 in byte mode
  assign ca = byte_n_i ? {1'b0, a_lat[10:0]} : {a_lat[10:0], dq_i[15]};
  assign u1 = ca == (byte_n_i ? 12'h555 : 12'hAAA);
  assign u2 = ca == (byte_n_i ? 12'h2AA : 12'h555);
  // address on the fall, data on the rise of the write strobe
  always @(negedge we_n_i) a_lat = addr_i;
  // sequence decoder; anything unexpected drops back to read
  always @(posedge we_n_i) if (!ce_n_i) begin
    case (step)
      3'h0: begin
        if (dq_i[7:0] == 8'hF0) ident = 1'b0;
        else if (bypass && dq_i[7:0] == 8'hA0) step = 3'h3;
        else if (bypass && dq_i[7:0] == 8'h90) step = 3'h7;
        else if (!bypass && dq_i[7:0] == 8'hAA && u1) step = 3'h1;
      end // suspend and resume need no state here
      3'h1: step = (dq_i[7:0] == 8'h55 && u2) ? 3'h2 : 3'h0;
      3'h2: begin
        step = 3'h0;
        if (dq_i[7:0] == 8'hF0) ident = 1'b0;
        else if (u1 && dq_i[7:0] == 8'h90) ident = 1'b1;
        else if (u1 && dq_i[7:0] == 8'hA0) step = 3'h3;
        else if (u1 && dq_i[7:0] == 8'h20) bypass = 1'b1;
        else if (u1 && dq_i[7:0] == 8'h80) step = 3'h4;
      end
      3'h3: begin
        step = 3'h0;
        if (a_lat[19:12] != PROT_BLK) mem[a_lat[3:0]] &= dq_i;
      end
      3'h4: step = (dq_i[7:0] == 8'hAA && u1) ? 3'h5 : 3'h0;
      3'h5: step = (dq_i[7:0] == 8'h55 && u2) ? 3'h6 : 3'h0;
      3'h6: begin
        step = 3'h0;
        if ((u1 && dq_i[7:0] == 8'h10) || dq_i[7:0] == 8'h30)
          foreach (mem[i]) mem[i] = 16'hFFFF;
      end
      default: begin
        step = 3'h0;
        if (dq_i[7:0] == 8'h00) bypass = 1'b0;
      end
    endcase
  end
  // read path: array, or codes in identification mode
  assign dq_en_o = !ce_n_i && !oe_n_i && we_n_i;
  always @* begin
    if (!ident) dq_o = mem[addr_i[3:0]];
    else case (addr_i[1:0])
      2'h0: dq_o = MAKER_CODE;
      2'h1: dq_o = PART_CODE;
      2'h2: dq_o = {15'h0, addr_i[19:12] == PROT_BLK};
      default: dq_o = 16'h0000;
    endcase
  end
endmodule : fcd_flash_model
`default_nettype wire

// [tb/tb.sv]
// self-checking bench: wishbone master, host and flash model
// assumes the host answers each bus access with one registered ack
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [3:0] op;
    logic [20:0] a;
    logic [15:0] d;
    logic [20:0] ra;
    logic [15:0] e;
  } fcd_row_s;
  localparam logic [15:0] MAKER = 16'h00A5; // arbitrary value
  localparam logic [15:0] PART = 16'h005A; // arbitrary value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] q;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o;
  wire logic [19:0] fa;
  wire logic ce_n, we_n, oe_n, dq_oe, top_o, top_oe, top_i, byte_n, m_en;
  wire logic [14:0] dq_o;
  wire logic [14:0] dq_i;
  wire logic [15:0] m_dq;
  int failures = 0;
  int checks_done = 0;
  // ordinary cases: op code, address, value, read-back address, expected
  fcd_row_s rows [17] = '{
    '{4'h3, 21'h3, 16'h00F0, 21'h3, 16'h00F0},
    '{4'h3, 21'h3, 16'h0F0F, 21'h3, 16'h0000},
    '{4'h2, 21'h0, 16'h0, 21'h0, MAKER},
    '{4'hB, 21'h0, 16'h0, 21'h1, PART},
    '{4'hB, 21'h0, 16'h0, 21'h01002, 16'h0001},
    '{4'hB, 21'h0, 16'h0, 21'h00006, 16'h0000},
    '{4'h0, 21'h0, 16'h0, 21'h3, 16'h0000},
    '{4'h3, 21'h01005, 16'h0, 21'h5, 16'hFFFF},
    '{4'h4, 21'h0, 16'h0, 21'h3, 16'h0000},
    '{4'h5, 21'h6, 16'h1234, 21'h6, 16'h1234},
    '{4'h6, 21'h0, 16'h0, 21'h6, 16'h1234},
    '{4'h2, 21'h0, 16'h0, 21'h1, PART},
    '{4'h1, 21'h0, 16'h0, 21'h6, 16'h1234},
    '{4'h7, 21'h0, 16'h0, 21'h3, 16'hFFFF},
    '{4'h3, 21'h7, 16'h00FF, 21'h7, 16'h00FF},
    '{4'h8, 21'h0, 16'h0, 21'h7, 16'hFFFF},
    '{4'hC, 21'h7, 16'h0, 21'h7, 16'hFFFF}
  };
  always #20 clk_i = ~clk_i;
  // released pins show the inverse so stale data never passes
  assign dq_i = dq_oe ? dq_o : (m_en ? m_dq[14:0] : ~m_dq[14:0]);
  assign top_i = top_oe ? top_o : (m_en ? m_dq[15] : ~m_dq[15]);
  fcd_host u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .fl_addr_o(fa), .fl_ce_n_o(ce_n), .fl_we_n_o(we_n), .fl_oe_n_o(oe_n),
    .fl_dq_i(dq_i), .fl_dq_o(dq_o), .fl_dq_oe_o(dq_oe),
    .top_data_or_low_address_pin_i(top_i),
    .top_data_or_low_address_pin_o(top_o),
    .top_data_or_low_address_pin_oe_o(top_oe), .fl_byte_n_o(byte_n));
  fcd_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash (
    .addr_i(fa), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n),
    .byte_n_i(byte_n), .dq_i({top_i, dq_i}), .dq_o(m_dq), .dq_en_o(m_en));
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one classic cycle; held until ack is sampled high
  // no cycle limit here: only the watchdog ends a hung bus
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // polls status; the host itself never polls the flash
  task automatic idle();
    int n;
    n = 0;
    do begin
      wb(1'b0, fcd_pkg::REG_STAT, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 500);
    if (n >= 500) failures++;
  endtask : idle
  task automatic run(input logic [3:0] op, input logic [20:0] a,
                     input logic [15:0] d, input logic b);
    wb(1'b1, fcd_pkg::REG_ADDR, {11'h0, a});
    wb(1'b1, fcd_pkg::REG_DATA, {16'h0, d});
    wb(1'b1, fcd_pkg::REG_CTRL, {24'h0, op, 2'b00, b, 1'b1});
    idle();
  endtask : run
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  // watchdog well past the expected run length
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, fcd_pkg::REG_STAT, 32'h0);
    chk("status reset", 16'h0, q[15:0]);
    wb(1'b0, 4'h1, 32'h0);
    chk("unmapped", 16'h0, q[15:0]);
    $display("test reset done");
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].a, rows[i].d, 1'b0);
      run(4'hB, rows[i].ra, 16'h0, 1'b0);
      wb(1'b0, fcd_pkg::REG_DATA, 32'h0);
      chk("row read", rows[i].e, q[31:16]);
    end
    $display("test table done");
    // a write while busy is dropped
    wb(1'b1, fcd_pkg::REG_ADDR, 32'h0000000A);
    wb(1'b1, fcd_pkg::REG_CTRL, 32'h00000001);
    wb(1'b1, fcd_pkg::REG_ADDR, 32'h0000000B);
    idle();
    wb(1'b0, fcd_pkg::REG_ADDR, 32'h0);
    chk("busy write", 16'h000A, q[15:0]);
    $display("test busy done");
    // byte-mode unlock addresses
    run(4'h2, 21'h0, 16'h0, 1'b1);
    run(4'hB, 21'h0, 16'h0, 1'b1);
    wb(1'b0, fcd_pkg::REG_DATA, 32'h0);
    chk("byte ident", {8'h0, MAKER[7:0]}, {8'h0, q[23:16]});
    run(4'h0, 21'h0, 16'h0, 1'b0);
    $display("test byte done");
    // suspend and resume status
    run(4'h9, 21'h0, 16'h0, 1'b0);
    wb(1'b0, fcd_pkg::REG_STAT, 32'h0);
    chk("suspended", 16'h0004, q[15:0] & 16'h0004);
    run(4'hA, 21'h0, 16'h0, 1'b0);
    wb(1'b0, fcd_pkg::REG_STAT, 32'h0);
    chk("resumed", 16'h0000, q[15:0] & 16'h0004);
    $display("test suspend done");
    // reset in mid-operation drops the sequence and the registers
    wb(1'b1, fcd_pkg::REG_CTRL, 32'h00000003);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, fcd_pkg::REG_STAT, 32'h0);
    chk("reset status", 16'h0, q[15:0]);
    wb(1'b0, fcd_pkg::REG_CTRL, 32'h0);
    chk("reset ctrl", 16'h0, q[15:0]);
    $display("test mid reset done");
    final_report();
  end
endmodule : tb
`default_nettype wire
